// ---- common/prt_pkg.sv ----
// constants and types shared by the prescaled reload timer
`default_nettype none
package prt_pkg;
    localparam int unsigned PRT_WIDTH = 8;

    // register byte offsets
    localparam logic [7:0] PRT_OFS_CONTROL   = 8'h00;
    localparam logic [7:0] PRT_OFS_MODE      = 8'h04;
    localparam logic [7:0] PRT_OFS_PRESCALER = 8'h08;
    localparam logic [7:0] PRT_OFS_PRIMARY   = 8'h0C;

    // control register fields
    localparam int unsigned PRT_CTL_START_POS  = 0;
    localparam int unsigned PRT_CTL_STOP_POS   = 1;
    localparam int unsigned PRT_CTL_STATUS_POS = 2;

    // mode register fields
    localparam int unsigned PRT_MODE_WRC_POS = 0;
    localparam int unsigned PRT_MODE_SRC_POS = 4;
    localparam int unsigned PRT_MODE_SRC_W   = 2;

    // reset values
    localparam logic [7:0] PRT_RELOAD_RST = 8'hFF;
    localparam logic       PRT_WRC_RST    = 1'b0;
    localparam logic [1:0] PRT_SRC_RST    = 2'h0;

    // count source encodings
    typedef enum logic [1:0] {
        PRT_SRC_DIV1  = 2'h0,
        PRT_SRC_DIV2  = 2'h1,
        PRT_SRC_DIV8  = 2'h2,
        PRT_SRC_COMPANION = 2'h3
    } prt_src_t;

    // peripheral clock divider masks, one less than the divide ratio
    localparam logic [2:0] PRT_DIV2_MASK = 3'h1;
    localparam logic [2:0] PRT_DIV8_MASK = 3'h7;
endpackage
`default_nettype wire

// ---- design/prt_source_sel.sv ----
// count source selection: one-cycle tick from divided clock or companion underflow
`default_nettype none
module prt_source_sel (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // control
    input  wire logic             run,
    input  wire prt_pkg::prt_src_t sel,
    input  wire logic             companion_uf,
    // tick out
    output logic                  tick
);
    import prt_pkg::*;

    typedef struct packed {
        logic [2:0] div;
    } prt_src_state_t;

    prt_src_state_t st_reg;
    prt_src_state_t st_next;

    always_comb begin
        st_next = st_reg;
        // divider rests while stopped so the first tick comes a fixed time after start
        if (run) begin
            st_next.div = st_reg.div + 3'h1;
        end else begin
            st_next.div = 3'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    always_comb begin
        case (sel)
            PRT_SRC_DIV1:      tick = run;
            PRT_SRC_DIV2:      tick = run && ((st_reg.div & PRT_DIV2_MASK) == PRT_DIV2_MASK);
            PRT_SRC_DIV8:      tick = run && ((st_reg.div & PRT_DIV8_MASK) == PRT_DIV8_MASK);
            PRT_SRC_COMPANION: tick = run && companion_uf;
            default:           tick = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ---- design/prt_stage.sv ----
// one reload stage: reload register, down counter, pending counter load
`default_nettype none
module prt_stage #(
    parameter int unsigned W = 8
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    // control
    input  wire logic         count,
    input  wire logic         force_init,
    input  wire logic [W-1:0] init_value,
    input  wire logic         wr,
    input  wire logic         wr_counter,
    input  wire logic [W-1:0] wr_data,
    // state
    output logic [W-1:0]      counter,
    output logic              underflow
);
    typedef struct packed {
        logic [W-1:0] reload;
        logic [W-1:0] cnt;
        logic         pend;
    } prt_stage_state_t;

    prt_stage_state_t st_reg;
    prt_stage_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (count) begin
            if (st_reg.pend) begin
                st_next.cnt  = st_reg.reload;
                st_next.pend = 1'b0;
            end else if (st_reg.cnt == '0) begin
                st_next.cnt = st_reg.reload;
            end else begin
                st_next.cnt = st_reg.cnt - 1'b1;
            end
        end
        // the counter waits for the next count pulse; the write never touches it directly
        if (wr) begin
            st_next.reload = wr_data;
            if (wr_counter) begin
                st_next.pend = 1'b1;
            end
        end
        if (force_init) begin
            st_next.reload = init_value;
            st_next.cnt    = init_value;
            st_next.pend   = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{reload: '1, cnt: '1, pend: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign counter   = st_reg.cnt;
    assign underflow = count && !st_reg.pend && (st_reg.cnt == '0);
endmodule
`default_nettype wire

// ---- design/prt_timer.sv ----
// prescaled reload timer, timer mode, with apb register access
//
// The implementer's own choices: the APB register port and the placing of the registers.
`default_nettype none
module prt_timer #(
    parameter int unsigned W = prt_pkg::PRT_WIDTH
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // companion timer underflow, one-cycle pulse
    input  wire logic        companion_uf,
    // interrupt request, high for one cycle per timer underflow
    output logic             timer_irq
);
    import prt_pkg::*;

    typedef struct packed {
        logic       start;
        logic       wrc;
        prt_src_t   src;
        logic [31:0] rdata;
        logic       slverr;
        logic       irq;
    } prt_state_t;

    prt_state_t st_reg;
    prt_state_t st_next;

    logic         acc;
    logic         wr_acc;
    logic         rd_acc;
    logic         mapped;
    logic         src_tick;
    logic         pre_uf;
    logic         tmr_uf;
    logic         force_stop;
    logic         wr_pre;
    logic         wr_pri;
    logic         wr_both;
    logic [W-1:0] pre_cnt;
    logic [W-1:0] tmr_cnt;

    assign acc    = psel && penable;
    assign wr_acc = acc && pwrite;
    assign rd_acc = acc && !pwrite;
    assign mapped = (paddr == PRT_OFS_CONTROL) || (paddr == PRT_OFS_MODE)
                 || (paddr == PRT_OFS_PRESCALER) || (paddr == PRT_OFS_PRIMARY);

    assign force_stop = wr_acc && (paddr == PRT_OFS_CONTROL)
                     && pwdata[PRT_CTL_STOP_POS];
    assign wr_pre  = wr_acc && (paddr == PRT_OFS_PRESCALER);
    assign wr_pri  = wr_acc && (paddr == PRT_OFS_PRIMARY);
    // stopped, or counting with write control 0, reaches the counter too
    assign wr_both = !st_reg.start || !st_reg.wrc;

    prt_source_sel u_src (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .run          (st_reg.start),
        .sel          (st_reg.src),
        .companion_uf (companion_uf),
        .tick         (src_tick)
    );

    prt_stage #(.W(W)) u_pre (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .count      (src_tick),
        .force_init (force_stop),
        .init_value (PRT_RELOAD_RST),
        .wr         (wr_pre),
        .wr_counter (wr_both),
        .wr_data    (pwdata[W-1:0]),
        .counter    (pre_cnt),
        .underflow  (pre_uf)
    );

    // timer stage steps only on prescaler underflow, giving the product ratio
    prt_stage #(.W(W)) u_tmr (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .count      (pre_uf),
        .force_init (force_stop),
        .init_value (PRT_RELOAD_RST),
        .wr         (wr_pri),
        .wr_counter (wr_both),
        .wr_data    (pwdata[W-1:0]),
        .counter    (tmr_cnt),
        .underflow  (tmr_uf)
    );

    always_comb begin
        st_next        = st_reg;
        st_next.irq    = tmr_uf;
        st_next.slverr = 1'b0;
        if (wr_acc) begin
            case (paddr)
                PRT_OFS_CONTROL: begin
                    st_next.start = pwdata[PRT_CTL_START_POS];
                end
                PRT_OFS_MODE: begin
                    // software keeps write control meaningful only in timer mode
                    st_next.wrc = pwdata[PRT_MODE_WRC_POS];
                    // source change is only safe while stopped
                    if (!st_reg.start) begin
                        st_next.src = prt_src_t'(pwdata[PRT_MODE_SRC_POS +: PRT_MODE_SRC_W]);
                    end
                end
                default: begin
                end
            endcase
            st_next.slverr = !mapped;
        end
        if (force_stop) begin
            st_next.start = 1'b0;
        end
        if (rd_acc) begin
            st_next.slverr = !mapped;
            case (paddr)
                PRT_OFS_CONTROL: begin
                    st_next.rdata = 32'h0;
                    st_next.rdata[PRT_CTL_START_POS]  = st_reg.start;
                    st_next.rdata[PRT_CTL_STATUS_POS] = st_reg.start;
                end
                PRT_OFS_MODE: begin
                    st_next.rdata = 32'h0;
                    st_next.rdata[PRT_MODE_WRC_POS] = st_reg.wrc;
                    st_next.rdata[PRT_MODE_SRC_POS +: PRT_MODE_SRC_W] = st_reg.src;
                end
                PRT_OFS_PRESCALER: st_next.rdata = {{(32-W){1'b0}}, pre_cnt};
                PRT_OFS_PRIMARY:   st_next.rdata = {{(32-W){1'b0}}, tmr_cnt};
                default:           st_next.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{start: 1'b0, wrc: PRT_WRC_RST, src: PRT_SRC_DIV1,
                        rdata: 32'h0, slverr: 1'b0, irq: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // zero-wait slave: answer in the first access cycle; rdata is registered on
    // the setup-to-access edge would need lookahead, so read data is combinational
    // from counters captured at that same edge
    assign pready    = 1'b1;
    assign prdata    = rd_acc ? read_now(paddr) : st_reg.rdata;
    assign pslverr   = acc && !mapped;
    assign timer_irq = st_reg.irq;

    function automatic logic [31:0] read_now(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0;
        case (a)
            PRT_OFS_CONTROL: begin
                v[PRT_CTL_START_POS]  = st_reg.start;
                v[PRT_CTL_STATUS_POS] = st_reg.start;
            end
            PRT_OFS_MODE: begin
                v[PRT_MODE_WRC_POS] = st_reg.wrc;
                v[PRT_MODE_SRC_POS +: PRT_MODE_SRC_W] = st_reg.src;
            end
            PRT_OFS_PRESCALER: v[W-1:0] = pre_cnt;
            PRT_OFS_PRIMARY:   v[W-1:0] = tmr_cnt;
            default:           v = 32'h0;
        endcase
        return v;
    endfunction
endmodule
`default_nettype wire

// ---- tb/prt_timer_props.sv ----
// port checker for the prescaled reload timer
`default_nettype none
module prt_timer_props (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // timer
    input wire logic        companion_uf,
    input wire logic        timer_irq
);
    import prt_pkg::*;
    logic       acc, rd, wr_ctl, ctr_adr, mapped;
    logic       run_reg, clean_reg, wc_reg;
    logic [1:0] idle_reg, src_reg;
    assign acc = psel && penable;
    assign rd = acc && !pwrite;
    assign wr_ctl = acc && pwrite && paddr == PRT_OFS_CONTROL;
    assign ctr_adr = paddr == PRT_OFS_PRESCALER || paddr == PRT_OFS_PRIMARY;
    assign mapped = ctr_adr || paddr == PRT_OFS_CONTROL || paddr == PRT_OFS_MODE;
    // shadow of start, mode and "counters still all ones" as seen from the bus
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            run_reg <= 1'b0;
            clean_reg <= 1'b1;
            wc_reg <= 1'b0;
            src_reg <= 2'h0;
            idle_reg <= 2'h0;
        end else begin
            if (wr_ctl)
                run_reg <= pwdata[0] && !pwdata[1];
            if (wr_ctl && pwdata[1])
                clean_reg <= 1'b1;
            else if (run_reg || (acc && pwrite && ctr_adr))
                clean_reg <= 1'b0;
            if (acc && pwrite && paddr == PRT_OFS_MODE) begin
                wc_reg <= pwdata[0];
                if (!run_reg)
                    src_reg <= pwdata[5:4];
            end
            idle_reg <= run_reg ? 2'h0 : (idle_reg == 2'h3 ? 2'h3 : idle_reg + 2'h1);
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (acc && !mapped |-> pslverr) else $error("no slave error");
    a_ctl_start: assert property (rd && paddr == PRT_OFS_CONTROL |-> prdata[0] == run_reg)
        else $error("start bit readback wrong");
    a_ctl_status: assert property (rd && paddr == PRT_OFS_CONTROL |->
        prdata[2] == prdata[0] && !prdata[1]) else $error("status bit wrong");
    a_width_read: assert property (rd && mapped |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_force_init: assert property (rd && ctr_adr && clean_reg |->
        prdata[7:0] == PRT_RELOAD_RST) else $error("counter not all ones");
    a_stop_quiet: assert property (idle_reg == 2'h3 |-> !timer_irq)
        else $error("interrupt while stopped");
    a_force_quiet: assert property (wr_ctl && pwdata[1] |=> ##2 !timer_irq [*4])
        else $error("interrupt after forced stop");
    a_mode_hold: assert property (rd && paddr == PRT_OFS_MODE |->
        prdata[5:4] == src_reg && prdata[0] == wc_reg) else $error("mode readback wrong");
    c_irq: cover property (timer_irq);
    c_force: cover property (wr_ctl && pwdata[1]);
    c_unmapped: cover property (acc && !mapped);
    c_reload_only: cover property (acc && pwrite && paddr == PRT_OFS_PRIMARY && run_reg && wc_reg);
endmodule
bind prt_timer prt_timer_props u_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .companion_uf(companion_uf), .timer_irq(timer_irq)
);
`default_nettype wire

// ---- tb/prt_timer_tb_top.sv ----
// self-checking bench for the prescaled reload timer
`default_nettype none
module prt_timer_tb_top import prt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys, rst_n, psel, penable, pwrite, companion_uf;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, timer_irq;
    logic [31:0] expq[$];
    int          n_fail = 0, num_checks = 0, cyc = 0, t_irq, t, g;
    int          div[4] = '{1, 2, 8, 4};
    integer      seed;

    prt_timer u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .companion_uf(companion_uf), .timer_irq(timer_irq));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // companion underflow every fourth cycle
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        companion_uf <= (cyc % 4 == 3);
    end

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    always @(posedge clk_sys) begin
        if (psel && penable && !pwrite && pready === 1'b1)
            check("prdata", expq.pop_front(), prdata);
    end

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task wirq();
        int k;
        k = 0;
        do begin
            @(negedge clk_sys);
            k++;
        end while (timer_irq !== 1'b1 && k < 3000);
        if (k >= 3000)
            n_fail++;
        t_irq = cyc;
    endtask
    task wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys);
        n_fail++;
        wrap_up();
    end

    initial begin
        seed = 32'h17DA;
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(PRT_OFS_PRESCALER, 32'hFF);
        rd(PRT_OFS_PRIMARY, 32'hFF);
        rd(PRT_OFS_MODE, 32'h0);
        rd(8'h10, 32'h0);
        wr(PRT_OFS_PRESCALER, 32'h2);
        rd(PRT_OFS_PRESCALER, 32'hFF);
        for (int s = 0; s < 4; s++) begin
            r = $random(seed);
            wr(PRT_OFS_CONTROL, 32'h2);
            wr(PRT_OFS_MODE, {26'h0, s[1:0], 4'h0});
            wr(PRT_OFS_PRESCALER, {30'h0, r[1:0]});
            wr(PRT_OFS_PRIMARY, {30'h0, r[3:2]});
            wr(PRT_OFS_CONTROL, 32'h1);
            rd(PRT_OFS_CONTROL, 32'h5);
            // source change must be refused while counting
            wr(PRT_OFS_MODE, {26'h0, s[1:0] + 2'h1, 4'h0});
            rd(PRT_OFS_MODE, {26'h0, s[1:0], 4'h0});
            wirq();
            t = t_irq;
            wirq();
            check("period", (r[1:0] + 1) * (r[3:2] + 1) * div[s], t_irq - t);
        end
        wr(PRT_OFS_CONTROL, 32'h0);
        rd(PRT_OFS_CONTROL, 32'h0);
        wr(PRT_OFS_CONTROL, 32'h2);
        wr(PRT_OFS_PRESCALER, 32'h0);
        wr(PRT_OFS_PRIMARY, 32'h9);
        // source back to the plain clock while stopped, reload-only writes
        wr(PRT_OFS_MODE, 32'h1);
        wr(PRT_OFS_CONTROL, 32'h1);
        wirq();
        t = t_irq;
        wr(PRT_OFS_PRIMARY, 32'h3);
        wirq();
        check("reload_only", 32'd10, t_irq - t);
        t = t_irq;
        wirq();
        check("new_period", 32'd4, t_irq - t);
        wr(PRT_OFS_MODE, 32'h0);
        wirq();
        t = t_irq;
        wr(PRT_OFS_PRIMARY, 32'h14);
        wirq();
        check("counter_write", 32'h1, {31'h0, (t_irq - t) > 4});
        wr(PRT_OFS_CONTROL, 32'h2);
        rd(PRT_OFS_CONTROL, 32'h0);
        rd(PRT_OFS_PRESCALER, 32'hFF);
        rd(PRT_OFS_PRIMARY, 32'hFF);
        wrap_up();
    end
endmodule
`default_nettype wire
